/* inc/lgc_regs.svh */
`ifndef LGC_REGS_SVH
`define LGC_REGS_SVH
// Register offsets (byte addresses on the plain register port).
`define LGC_GCR1_ADDR 12'hfe1
`define LGC_GCR2_ADDR 12'hfe2
`define LGC_PMC_ADDR 12'hfe0
`define LGC_STAT_ADDR 12'hfe8
`define LGC_ICLR_ADDR 12'hfe9
`define LGC_IEN_ADDR 12'hfea
`define LGC_SEG_BASE 12'hf08
// Field positions.
`define LGC_GCR1_EXLOSS_BIT 1
`define LGC_GCR1_TEST_BIT 0
`define LGC_PMC_ARB_BIT 3
`define LGC_PMC_MUTE_BIT 2
`define LGC_ST_LOS_SET_BIT 0
`define LGC_ST_LOS_CLR_BIT 1
// Reset values.
`define LGC_GCR1_RST 8'h00
`define LGC_GCR2_RST 8'h00
`define LGC_PMC_RST 8'h00
`define LGC_SEG_RST 8'h00
// Loss detection zero counts.
`define LGC_LOS_NORMAL 13'd175
`define LGC_LOS_EXTENDED 13'd4096
`endif

/* inc/lgc_pkg.sv */
`default_nettype none
package lgc_pkg;
   // Control bits that steer the line interface.
   typedef struct packed {
      logic arb_enable;
      logic mute_enable;
      logic ext_loss;
      logic in_circuit_test_enable;
   } lgc_ctl_s;
   // State of the block, apart from the line synchroniser.
   typedef struct packed {
      logic [7:0] gcr1;
      logic [7:0] gcr2;
      logic [7:0] pmc;
      logic [7:0][7:0] seg;
      logic [12:0] zero_cnt;
      logic los;
      logic [1:0] status;
      logic [1:0] irq_en;
      logic irq;
      logic [7:0] rdata;
      logic rx_data;
      logic [7:0] tx_level;
      logic [2:0] tx_phase;
      logic tx_oe;
   } lgc_state_s;
endpackage
`default_nettype wire

/* core/lgc_global_ctl.sv */
// Notes on behaviour
// RULE_01: Arbitrary pulse uses eight segment registers.
// RULE_02: Mute receive data to zeros during loss.
// RULE_03: Extended mode declares loss after 4096 zeros.
// RULE_04: Normal mode declares loss after 175 zeros.
// RULE_05: In-circuit test tristates all outputs; the code releases only tx_oe, and the other outputs stay driven.
// RULE_06: Software writes zero to second register.
// RULE_07: Any received one restarts the zero counter.
`timescale 1ns/1ps
`default_nettype none
`include "lgc_regs.svh"
module lgc_global_ctl
   import lgc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic rx_line, // Raw received bit, from a pin.
   input wire logic rx_bit_en, // One-cycle enable per received bit.
   input wire logic tx_bit_en, // One-cycle enable per transmit segment.
   input wire logic tx_mark, // Transmit a mark in the coming bit.
   output logic rx_data, // Recovered data toward the framer.
   output logic receive_loss_of_signal, // High while loss is declared.
   output logic [7:0] tx_level, // Pulse amplitude toward the driver.
   output logic tx_oe, // High while the transmit pin is driven.
   output logic irq // Level interrupt from the enabled status bits.
);
   // Synchroniser for the line input.
   logic rx_meta_reg;
   logic rx_sync_reg;
   // State register and its next value.
   lgc_state_s st_reg;
   lgc_state_s st_next;
   // Decoded control bits.
   lgc_ctl_s ctl;

   // Normal shaped pulse level for a segment of a mark.
   // Segments 0 to 3 carry the pulse, 4 to 7 the return to zero.
   function automatic logic [7:0] normal_level(input logic [2:0] ph);
      normal_level = (ph < 3'h4) ? 8'h7f : 8'h00;
   endfunction

   // Segment registers fill one aligned block of eight addresses; both
   // the write and the read decode go through this check.
   function automatic logic is_seg(input logic [11:0] a);
      logic [11:0] base;
      base = `LGC_SEG_BASE;
      is_seg = (a[11:3] == base[11:3]);
   endfunction

   // Two flip-flops bring the line input into the clock domain.
   // Only the second stage is read by logic, so a metastable first
   // stage never reaches the loss counter.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         // Both stages start low, like a quiet line.
         rx_meta_reg <= 1'b0;
         rx_sync_reg <= 1'b0;
      end else begin
         // Shift the line level one stage per clock.
         rx_meta_reg <= rx_line;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // Control fields picked from the registers.
   // They steer the logic below and are never stored on their own.
   always_comb begin
      ctl.arb_enable = st_reg.pmc[`LGC_PMC_ARB_BIT];
      ctl.mute_enable = st_reg.pmc[`LGC_PMC_MUTE_BIT];
      ctl.ext_loss = st_reg.gcr1[`LGC_GCR1_EXLOSS_BIT];
      ctl.in_circuit_test_enable = st_reg.gcr1[`LGC_GCR1_TEST_BIT];
   end

   // Next-state logic for the whole block: register writes, loss
   // detection, receive muting, pulse shaping, events and read data.
   always_comb begin
      logic [12:0] limit; // Zero count at which loss is declared.
      logic los_set_ev; // Loss declared on this bit.
      logic los_clr_ev; // Loss ended on this bit.
      logic [7:0] lvl; // Amplitude chosen for this segment.
      limit = 13'd0;
      los_set_ev = 1'b0;
      los_clr_ev = 1'b0;
      lvl = 8'h00;
      st_next = st_reg;
      // Register writes; the second register is kept as written.
      if (wr) begin
         if (addr == `LGC_GCR1_ADDR) begin
            // Extended loss and in-circuit test bits.
            st_next.gcr1 = wdata;
         end else if (addr == `LGC_GCR2_ADDR) begin
            // No function; stored so that software reads it back.
            st_next.gcr2 = wdata;
         end else if (addr == `LGC_PMC_ADDR) begin
            // Arbitrary pulse and receive mute bits.
            st_next.pmc = wdata;
         end else if (addr == `LGC_IEN_ADDR) begin
            // Interrupt enables share the layout of the status bits.
            st_next.irq_en = wdata[1:0];
         end else if (is_seg(addr)) begin
            // One of the eight pulse segment amplitudes.
            st_next.seg[addr[2:0]] = wdata; // RULE_01
         end
      end
      // Loss detection on the synchronised line bit.
      limit = ctl.ext_loss ? `LGC_LOS_EXTENDED : `LGC_LOS_NORMAL; // RULE_03
      if (rx_bit_en) begin
         if (rx_sync_reg) begin
            // A one breaks the run of zeros and ends any loss.
            st_next.zero_cnt = 13'd0; // RULE_07
            if (st_reg.los) begin
               st_next.los = 1'b0;
               los_clr_ev = 1'b1;
            end
         end else begin
            // The count stops at the limit so that it cannot wrap.
            if (st_reg.zero_cnt < limit) begin
               st_next.zero_cnt = st_reg.zero_cnt + 13'd1;
            end
            // Declared on the zero that completes the run; the level
            // then stands until a one arrives.
            if (!st_reg.los && (st_reg.zero_cnt + 13'd1 >= limit)) begin
               st_next.los = 1'b1; // RULE_04
               los_set_ev = 1'b1;
            end
         end
         // A bit that arrives while loss stands is muted, the one that
         // ends the loss included, so no stray bit reaches the framer.
         if (ctl.mute_enable && st_reg.los) begin
            st_next.rx_data = 1'b0; // RULE_02
         end else begin
            // Muting off or no loss: the bit passes unchanged.
            st_next.rx_data = rx_sync_reg; // RULE_02
         end
      end
      // Transmit pulse shaping, one segment per enable.
      if (tx_bit_en) begin
         // The phase wraps after the eighth segment of a bit.
         st_next.tx_phase = st_reg.tx_phase + 3'h1;
         if (tx_mark) begin
            // A mark takes the programmed or the normal amplitude.
            lvl = ctl.arb_enable ? st_reg.seg[st_reg.tx_phase] :
               normal_level(st_reg.tx_phase); // RULE_01
         end
         // A space leaves the amplitude at zero.
         st_next.tx_level = lvl;
      end
      // The driver is released while in-circuit test is set.
      st_next.tx_oe = !ctl.in_circuit_test_enable; // RULE_05
      // Clear register, with a new event winning over the clear.
      if (wr && addr == `LGC_ICLR_ADDR) begin
         // Each written one clears its sticky bit.
         st_next.status = st_reg.status & ~wdata[1:0];
      end
      // Events are applied after the clear so that none is lost.
      if (los_set_ev) begin
         st_next.status[`LGC_ST_LOS_SET_BIT] = 1'b1;
      end
      if (los_clr_ev) begin
         st_next.status[`LGC_ST_LOS_CLR_BIT] = 1'b1;
      end
      // The interrupt follows the status that is being stored.
      st_next.irq = |(st_next.status & st_next.irq_en);
      // Read data, valid in the cycle after the strobe and zero else.
      st_next.rdata = 8'h00;
      if (rd) begin
         if (addr == `LGC_GCR1_ADDR) begin
            st_next.rdata = st_reg.gcr1;
         end else if (addr == `LGC_GCR2_ADDR) begin
            st_next.rdata = st_reg.gcr2;
         end else if (addr == `LGC_PMC_ADDR) begin
            st_next.rdata = st_reg.pmc;
         end else if (addr == `LGC_STAT_ADDR) begin
            // Live loss level above the two sticky event bits.
            st_next.rdata = {5'h00, st_reg.los, st_reg.status};
         end else if (addr == `LGC_IEN_ADDR) begin
            // Enables read back in the status layout.
            st_next.rdata = {6'h00, st_reg.irq_en};
         end else if (is_seg(addr)) begin
            // Segment amplitudes read back as written.
            st_next.rdata = st_reg.seg[addr[2:0]];
         end
         // Unmapped addresses and the clear register read as zero.
      end
   end

   // State register with constant reset values.
   // Every field starts at zero except the driver enable, which is
   // high so that the transmit pin drives from reset on.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         // Clear everything first, then the documented defaults.
         st_reg <= '0;
         st_reg.gcr1 <= `LGC_GCR1_RST;
         st_reg.gcr2 <= `LGC_GCR2_RST;
         st_reg.pmc <= `LGC_PMC_RST;
         st_reg.tx_oe <= 1'b1;
      end else begin
         // Register the next state as a whole.
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state flip-flops.
   // Register port read data.
   assign rdata = st_reg.rdata;
   // Receive side toward the framer.
   assign rx_data = st_reg.rx_data;
   assign receive_loss_of_signal = st_reg.los;
   // Transmit side toward the line driver.
   assign tx_level = st_reg.tx_level;
   assign tx_oe = st_reg.tx_oe;
   assign irq = st_reg.irq;
endmodule
`default_nettype wire

/* bench/lgc_global_ctl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lgc_regs.svh"
// Port-level checks on the line interface control block.
module lgc_global_ctl_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rx_line,
   input wire logic rx_bit_en,
   input wire logic tx_bit_en,
   input wire logic tx_mark,
   input wire logic rx_data,
   input wire logic receive_loss_of_signal,
   input wire logic [7:0] tx_level,
   input wire logic tx_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_test_on;
      wr && addr == `LGC_GCR1_ADDR && wdata[`LGC_GCR1_TEST_BIT]
         |-> ##[1:2] !tx_oe;
   endproperty
   a_test_on: assert property (p_test_on) else $error("tx_oe on");
   property p_test_off;
      wr && addr == `LGC_GCR1_ADDR && !wdata[`LGC_GCR1_TEST_BIT]
         |-> ##[1:2] tx_oe;
   endproperty
   a_test_off: assert property (p_test_off) else $error("tx_oe off");
   property p_one;
      rx_bit_en && $past(rx_line, 2) |=> !receive_loss_of_signal;
   endproperty
   a_one: assert property (p_one) else $error("loss after one");
   property p_rise;
      $rose(receive_loss_of_signal) |-> $past(rx_bit_en);
   endproperty
   a_rise: assert property (p_rise) else $error("loss off bit");
   property p_space;
      tx_bit_en && !tx_mark |=> tx_level == 8'h00;
   endproperty
   a_space: assert property (p_space) else $error("space level");
   property p_hold;
      !rx_bit_en |=> $stable(rx_data);
   endproperty
   a_hold: assert property (p_hold) else $error("rx_data moved");
endmodule
bind lgc_global_ctl lgc_global_ctl_chk chk_i (.clk(clk), .reset_n(reset_n),
   .addr(addr), .wdata(wdata), .wr(wr), .rx_line(rx_line),
   .rx_bit_en(rx_bit_en), .tx_bit_en(tx_bit_en), .tx_mark(tx_mark),
   .rx_data(rx_data), .receive_loss_of_signal(receive_loss_of_signal),
   .tx_level(tx_level), .tx_oe(tx_oe));
`default_nettype wire

/* bench/lgc_global_ctl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lgc_global_ctl_tb_top;
   logic clk = 1'h0, reset_n = 1'h0, wr = 1'h0, rd = 1'h0, rx_line = 1'h1;
   logic rx_bit_en = 1'h0, tx_bit_en = 1'h0, tx_mark = 1'h0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, tx_level;
   logic rx_data, los, tx_oe, irq;
   int errors = 0;
   int n_compared = 0;
   lgc_global_ctl dut (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_line(rx_line),
      .rx_bit_en(rx_bit_en), .tx_bit_en(tx_bit_en), .tx_mark(tx_mark),
      .rx_data(rx_data), .receive_loss_of_signal(los),
      .tx_level(tx_level), .tx_oe(tx_oe), .irq(irq));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic cmp(string nm, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic wr_reg(logic [11:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd_chk(logic [11:0] a, logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 cmp("rdata", exp, rdata);
   endtask
   // Hold the line level long enough to pass the synchroniser, then
   // present n bits back to back.
   task automatic run(int n, logic v);
      @(posedge clk);
      rx_line <= v;
      repeat (3) @(posedge clk);
      repeat (n) begin
         rx_bit_en <= 1'h1;
         @(posedge clk);
      end
      rx_bit_en <= 1'h0;
      @(posedge clk);
      #1;
   endtask
   // One transmit segment, then the amplitude it left on the driver.
   task automatic tx_seg(logic m, logic [7:0] exp);
      @(posedge clk);
      tx_mark <= m;
      tx_bit_en <= 1'h1;
      @(posedge clk);
      tx_bit_en <= 1'h0;
      #1 cmp("tx_level", exp, tx_level);
   endtask
   task automatic close_out;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #500000;
      errors++;
      close_out;
   end
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'h1;
      @(posedge clk);
      rd_chk(12'hfe1, 8'h00);
      rd_chk(12'h100, 8'h00);
      wr_reg(12'hfe2, 8'h00);
      rd_chk(12'hfe2, 8'h00);
      wr_reg(12'hfe1, 8'h01);
      cmp("tx_oe", 1'h0, tx_oe);
      wr_reg(12'hfe1, 8'h00);
      cmp("tx_oe", 1'h1, tx_oe);
      wr_reg(12'hf08, 8'h5a);
      wr_reg(12'hfe0, 8'h08);
      tx_seg(1'h1, 8'h5a);
      wr_reg(12'hfe0, 8'h04);
      tx_seg(1'h1, 8'h7f);
      tx_seg(1'h0, 8'h00);
      wr_reg(12'hf0b, 8'hc3);
      rd_chk(12'hf0b, 8'hc3);
      wr_reg(12'hfe0, 8'h0c);
      tx_seg(1'h1, 8'hc3);
      wr_reg(12'hfe0, 8'h04);
      tx_seg(1'h1, 8'h00);
      wr_reg(12'hfea, 8'h01);
      run(1, 1'h1);
      cmp("rx_data", 1'h1, rx_data);
      run(174, 1'h0);
      cmp("los", 1'h0, los);
      run(1, 1'h0);
      cmp("los", 1'h1, los);
      cmp("rx_data", 1'h0, rx_data);
      cmp("irq", 1'h1, irq);
      rd_chk(12'hfe8, 8'h05);
      wr_reg(12'hfea, 8'h00);
      cmp("irq", 1'h0, irq);
      wr_reg(12'hfe9, 8'h01);
      wr_reg(12'hfea, 8'h01);
      cmp("irq", 1'h0, irq);
      wr_reg(12'hfe1, 8'h02);
      run(1, 1'h1);
      cmp("rx_data", 1'h0, rx_data);
      cmp("los", 1'h0, los);
      run(4095, 1'h0);
      run(1, 1'h1);
      run(4095, 1'h0);
      cmp("los", 1'h0, los);
      run(1, 1'h0);
      cmp("los", 1'h1, los);
      rd_chk(12'hfe8, 8'h07);
      wr_reg(12'hfe0, 8'h00);
      run(1, 1'h1);
      cmp("rx_data", 1'h1, rx_data);
      cmp("los", 1'h0, los);
      wr_reg(12'hfe9, 8'h02);
      rd_chk(12'hfe8, 8'h01);
      close_out;
   end
endmodule
`default_nettype wire
